// [hw/osd_sync_position_timing.sv]
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module osd_sync_position_timing
    import osd_timing_pkg::*;
#(
    parameter int CHARS = 512,
    parameter int CODE_W = $clog2(CHARS),
    parameter logic [CODE_W-1:0] BLANK_CODE = '0,
    parameter int CHAR_W = 12,       // Dots per cell
    parameter int CHAR_H = 18,       // Lines per cell
    parameter int DOT_DIV = 28,      // LC dot clock model
    parameter int FSC4_DIV = 14,     // 4fsc oscillator model
    parameter int LINE_TICKS = 910,  // Generator line, 4fsc ticks
    parameter int HS_TICKS = 67,
    parameter int FIELD_LINES = 262,
    parameter int VS_LINES = 3,
    parameter int VSEP_TH = 16,      // Vsync detect level, fsc ticks
    parameter int HOLDOFF = HOLDOFF_CYC,
    parameter int PSEUDO = PSEUDO_CYC
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Pins
    input wire logic power_on_clear,
    input wire logic hsync_n,
    input wire logic vsync_n,
    input wire logic csync_n,
    input wire logic dot_clk_ext,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Character position outputs
    output logic line_start,
    output logic dot_tick,
    output logic disp_active,
    output logic [4:0] cell_col,
    output logic [3:0] cell_row,
    output logic [4:0] font_line,
    output logic [CODE_W-1:0] char_code
);
    // ==========================================================
    // Helpers
    function automatic logic [31:0] strb_merge(input logic [31:0] o, input logic [31:0] n,
                                               input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            if (s[i]) o[8*i +: 8] = n[8*i +: 8];
        end
        return o;
    endfunction
    function automatic logic [VRAM_AW-1:0] cell_idx(input logic [3:0] r, input logic [4:0] c);
        return VRAM_AW'(r * COLS + c);
    endfunction

    // ==========================================================
    // Synchronisers and reset
    logic [1:0] hs_s, vs_s, cs_s, dk_s, poc_s; // Stage 0 read only by stage 1
    logic rst;
    logic dk_d;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            {hs_s, vs_s, cs_s, dk_s, poc_s} <= 10'h3fc;
        end else if (clk_en) begin
            hs_s <= {hs_s[0], hsync_n};
            vs_s <= {vs_s[0], vsync_n};
            cs_s <= {cs_s[0], csync_n};
            dk_s <= {dk_s[0], dot_clk_ext};
            poc_s <= {poc_s[0], power_on_clear};
        end
    end
    assign rst = sys_rst | poc_s[1]; // Power-on clear acts as reset

    // ==========================================================
    // Registers
    logic [CTRL_W-1:0] ctrl_r;
    logic [9:0] hstart_r;
    logic [8:0] vstart_r;
    logic [VRAM_AW-1:0] vaddr_r;
    logic aw_full_r, w_full_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic do_write, clr_go, vram_we;
    logic [1:0] src;
    assign src = ctrl_r[SRC_LSB +: 2];
    assign s_axi_awready = clk_en & ~aw_full_r & ~s_axi_bvalid;
    assign s_axi_wready = clk_en & ~w_full_r & ~s_axi_bvalid;
    assign s_axi_arready = clk_en & ~s_axi_rvalid;
    assign do_write = aw_full_r & w_full_r & ~s_axi_bvalid;
    assign clr_go = do_write && awaddr_r == CLEAR_OFS && wstrb_r[0] && wdata_r[0];
    assign vram_we = do_write && awaddr_r == VDATA_OFS;

    // Address and data are held separately so either may come first
    always_ff @(posedge core_clk) begin
        if (rst) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end else if (do_write) begin
                aw_full_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end else if (do_write) begin
                w_full_r <= 1'b0;
            end
        end
    end

    // Register writes and write response
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_r <= CTRL_RST;
            hstart_r <= HSTART_RST;
            vstart_r <= VSTART_RST;
            vaddr_r <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= RESP_OKAY;
                case (awaddr_r)
                    CTRL_OFS: ctrl_r <= CTRL_W'(strb_merge(32'(ctrl_r), wdata_r, wstrb_r));
                    HSTART_OFS: hstart_r <= 10'(strb_merge(32'(hstart_r), wdata_r, wstrb_r));
                    VSTART_OFS: vstart_r <= 9'(strb_merge(32'(vstart_r), wdata_r, wstrb_r));
                    VADDR_OFS: vaddr_r <= VRAM_AW'(strb_merge(32'(vaddr_r), wdata_r, wstrb_r));
                    VDATA_OFS, CLEAR_OFS: ;
                    STATUS_OFS: ;               // Read only, write ignored
                    default: s_axi_bresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Video memory and batch clear
    logic [CODE_W-1:0] vram [VRAM_WORDS];
    logic clr_busy_r;
    logic [VRAM_AW-1:0] clr_idx_r;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            clr_busy_r <= 1'b0;
            clr_idx_r <= '0;
        end else if (clk_en) begin
            if (clr_go && !clr_busy_r) begin
                clr_busy_r <= 1'b1;
                clr_idx_r <= '0;
            end else if (clr_busy_r) begin
                clr_idx_r <= clr_idx_r + 1'b1;
                if (clr_idx_r == VRAM_AW'(VRAM_WORDS - 1)) clr_busy_r <= 1'b0;
            end
        end
    end
    // Clear wins the single write port; software writes meanwhile are lost
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            if (clr_busy_r) begin
                vram[clr_idx_r] <= BLANK_CODE;
            end else if (vram_we && vaddr_r < VRAM_AW'(VRAM_WORDS)) begin
                vram[vaddr_r] <= CODE_W'(wdata_r);
            end
        end
    end

    // ==========================================================
    // Oscillators: dot clock, 4fsc and fsc
    logic [7:0] dot_div_r, fsc4_div_r;
    logic [1:0] fsc_div_r;
    logic lc_tick, fsc4_tick, fsc_tick, dot_halt;
    logic vs_raw, hs_raw;
    // Halting only while sync is low keeps the line start phase fixed
    assign dot_halt = ctrl_r[DISP_ON_BIT] & ~hs_raw;
    assign lc_tick = ctrl_r[LC_ON_BIT] && !dot_halt && dot_div_r == 8'(DOT_DIV - 1);
    assign dot_tick = ctrl_r[EXT_CLK_BIT] ? (dk_s[1] & ~dk_d) : lc_tick;
    assign fsc4_tick = ctrl_r[XTAL_ON_BIT] && fsc4_div_r == 8'(FSC4_DIV - 1);
    assign fsc_tick = fsc4_tick && fsc_div_r == 2'(FSC_DIV - 1);
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dot_div_r <= 8'h00;
            fsc4_div_r <= 8'h00;
            fsc_div_r <= 2'h0;
            dk_d <= 1'b0;
        end else if (clk_en) begin
            dk_d <= dk_s[1];
            if (dot_halt || lc_tick) dot_div_r <= 8'h00;
            else if (ctrl_r[LC_ON_BIT]) dot_div_r <= dot_div_r + 8'h01;
            if (fsc4_tick) fsc4_div_r <= 8'h00;
            else if (ctrl_r[XTAL_ON_BIT]) fsc4_div_r <= fsc4_div_r + 8'h01;
            if (fsc4_tick) fsc_div_r <= fsc_div_r + 2'h1;
        end
    end

    // ==========================================================
    // Internal sync generator and composite separation
    logic [9:0] gen_h_r;
    logic [8:0] gen_v_r;
    logic [4:0] vsep_r;
    logic vsep_low_r;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            gen_h_r <= 10'h000;
            gen_v_r <= 9'h000;
        end else if (clk_en && fsc4_tick) begin
            if (gen_h_r == 10'(LINE_TICKS - 1)) begin
                gen_h_r <= 10'h000;
                gen_v_r <= (gen_v_r == 9'(FIELD_LINES - 1)) ? 9'h000 : gen_v_r + 9'h001;
            end else begin
                gen_h_r <= gen_h_r + 10'h001;
            end
        end
    end
    // Counts down while composite is high, up while low; saturates
    always_ff @(posedge core_clk) begin
        if (rst) begin
            vsep_r <= 5'h00;
            vsep_low_r <= 1'b0;
        end else if (clk_en && fsc_tick) begin
            if (cs_s[1] && vsep_r != 5'h00) vsep_r <= vsep_r - 5'h01;
            else if (!cs_s[1] && vsep_r != 5'h1f) vsep_r <= vsep_r + 5'h01;
            if (vsep_r >= 5'(VSEP_TH)) vsep_low_r <= 1'b1;
            else if (vsep_r == 5'h00) vsep_low_r <= 1'b0;
        end
    end
    // Source select; all levels high when idle, low in the pulse
    always_comb begin
        case (src)
            SRC_CSYNC: begin
                hs_raw = cs_s[1];
                vs_raw = ~vsep_low_r;
            end
            SRC_GEN: begin
                hs_raw = gen_h_r >= 10'(HS_TICKS);
                vs_raw = gen_v_r >= 9'(VS_LINES);
            end
            default: begin
                hs_raw = hs_s[1];
                vs_raw = vs_s[1];
            end
        endcase
    end

    // ==========================================================
    // Hsync qualification: width, hold-off, pseudo sync
    logic hs_d, vs_d;
    logic [7:0] low_cnt_r;
    logic [13:0] since_r;
    logic accept, pseudo, hs_rise;
    assign hs_rise = hs_raw & ~hs_d;
    assign accept = hs_rise && since_r >= 14'(HOLDOFF)
        && low_cnt_r >= 8'(ctrl_r[WIDE_BIT] ? HS_MIN_WIDE_CYC : HS_MIN_NARROW_CYC);
    assign pseudo = !accept && since_r >= 14'(PSEUDO - 1);
    assign line_start = accept | pseudo;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hs_d <= 1'b1;
            vs_d <= 1'b1;
            low_cnt_r <= 8'h00;
            since_r <= 14'h0000;
        end else if (clk_en) begin
            hs_d <= hs_raw;
            vs_d <= vs_raw;
            if (hs_raw) low_cnt_r <= 8'h00;
            else if (low_cnt_r != 8'hff) low_cnt_r <= low_cnt_r + 8'h01;
            // A pseudo pulse also clears the count, so the hold-off starts again
            if (line_start) since_r <= 14'h0000;
            else since_r <= since_r + 14'h0001;
        end
    end

    // ==========================================================
    // Horizontal position
    logic [9:0] hdot_r;
    logic [3:0] cdot_r;
    logic hact_r;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hdot_r <= 10'h000;
            cdot_r <= 4'h0;
            hact_r <= 1'b0;
            cell_col <= 5'h00;
        end else if (clk_en) begin
            if (line_start) begin
                hdot_r <= 10'h000;
                hact_r <= 1'b0;
            end else if (dot_tick) begin
                hdot_r <= hdot_r + 10'h001;
                if (hdot_r + 10'h001 == hstart_r) begin
                    hact_r <= 1'b1;
                    cell_col <= 5'h00;
                    cdot_r <= 4'h0;
                end else if (hact_r) begin
                    cdot_r <= (cdot_r == 4'(CHAR_W - 1)) ? 4'h0 : cdot_r + 4'h1;
                    if (cdot_r == 4'(CHAR_W - 1)) begin
                        if (cell_col == 5'(COLS - 1)) hact_r <= 1'b0;
                        else cell_col <= cell_col + 5'h01;
                    end
                end
            end
        end
    end

    // ==========================================================
    // Vertical position
    logic [8:0] line_r;
    logic vact_r;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            line_r <= 9'h000;
            vact_r <= 1'b0;
            cell_row <= 4'h0;
            font_line <= 5'h00;
        end else if (clk_en) begin
            if (vs_raw && !vs_d) begin
                line_r <= 9'h000;
                vact_r <= 1'b0;
            end else if (line_start) begin
                line_r <= line_r + 9'h001;
                if (line_r + 9'h001 == vstart_r) begin
                    vact_r <= 1'b1;
                    cell_row <= 4'h0;
                    font_line <= 5'h00;
                end else if (vact_r) begin
                    font_line <= (font_line == 5'(CHAR_H - 1)) ? 5'h00 : font_line + 5'h01;
                    if (font_line == 5'(CHAR_H - 1)) begin
                        if (cell_row == 4'(ROWS - 1)) vact_r <= 1'b0;
                        else cell_row <= cell_row + 4'h1;
                    end
                end
            end
        end
    end

    // ==========================================================
    // Character fetch and register reads
    always_ff @(posedge core_clk) begin
        if (rst) begin
            char_code <= '0;
            disp_active <= 1'b0;
        end else if (clk_en) begin
            char_code <= vram[cell_idx(cell_row, cell_col)];
            disp_active <= hact_r & vact_r & ctrl_r[DISP_ON_BIT];
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                case (s_axi_araddr)
                    CTRL_OFS: s_axi_rdata <= 32'(ctrl_r);
                    HSTART_OFS: s_axi_rdata <= 32'(hstart_r);
                    VSTART_OFS: s_axi_rdata <= 32'(vstart_r);
                    VADDR_OFS: s_axi_rdata <= 32'(vaddr_r);
                    VDATA_OFS: s_axi_rdata <= (vaddr_r < VRAM_AW'(VRAM_WORDS)) ?
                        32'(vram[vaddr_r]) : 32'h0000_0000;
                    CLEAR_OFS: s_axi_rdata <= 32'(clr_busy_r);
                    STATUS_OFS: s_axi_rdata <= {11'h000, cell_col, 4'h0, cell_row,
                        3'h0, vs_raw, hs_raw, vact_r, hact_r, clr_busy_r};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // osd_sync_position_timing
`default_nettype wire

// [hw/osd_timing_pkg.sv]
package osd_timing_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_PERIOD_PS = 5000;   // 200 MHz core clock
    localparam int HS_MIN_NARROW_NS = 200; // Narrow-pulse variant
    localparam int HS_MIN_WIDE_NS = 800;   // Wide-pulse variant
    localparam int HOLDOFF_NS = 61200;     // Ignore window after a sample
    localparam int PSEUDO_NS = 64500;      // Window end for pseudo sync
    // Least times round up, longest times round down
    localparam int HS_MIN_NARROW_CYC = (HS_MIN_NARROW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HS_MIN_WIDE_CYC = (HS_MIN_WIDE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLDOFF_CYC = (HOLDOFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PSEUDO_CYC = (PSEUDO_NS * 1000) / CLK_PERIOD_PS;
    localparam int FSC_DIV = 4;            // 4fsc divided down to fsc
    // ==========================================================
    // Display area
    localparam int ROWS = 12;
    localparam int COLS = 24;
    localparam int VRAM_WORDS = ROWS * COLS; // 288 words
    localparam int VRAM_AW = 9;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] HSTART_OFS = 8'h04;
    localparam logic [7:0] VSTART_OFS = 8'h08;
    localparam logic [7:0] VADDR_OFS = 8'h0c;
    localparam logic [7:0] VDATA_OFS = 8'h10;
    localparam logic [7:0] CLEAR_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;
    // Control fields
    localparam int DISP_ON_BIT = 0;
    localparam int LC_ON_BIT = 1;
    localparam int EXT_CLK_BIT = 2;
    localparam int XTAL_ON_BIT = 3;
    localparam int SRC_LSB = 4;            // Two bits: sync source
    localparam int WIDE_BIT = 6;
    localparam int CTRL_W = 7;
    localparam logic [6:0] CTRL_RST = 7'h02; // LC on, all else off
    localparam logic [9:0] HSTART_RST = 10'h020;
    localparam logic [8:0] VSTART_RST = 9'h010;
    // Sync source selection
    localparam logic [1:0] SRC_PINS = 2'h0;
    localparam logic [1:0] SRC_CSYNC = 2'h1;
    localparam logic [1:0] SRC_GEN = 2'h2;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [verification/osd_timing_checker_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// ========
// Sync spacing and bus handshake checker
module osd_timing_checker
    import osd_timing_pkg::*;
#(
    parameter int HOLDOFF = 50,
    parameter int PSEUDO = 80
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Sync pin
    input wire logic hsync_n,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Line pulse
    input wire logic line_start
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic [15:0] gap_r; // Cycles since last line pulse
    logic [15:0] low_r; // Current low run on the pin
    logic [15:0] wid_r; // Width of last finished pulse
    logic [3:0] rise_r; // Cycles since last pin rise
    logic seen_r; // First pulse passed
    // ========
    // Line spacing
    always_ff @(posedge core_clk) begin
        if (sys_rst || line_start) begin
            gap_r <= 16'h0;
        end else if (clk_en && gap_r != 16'hffff) begin
            gap_r <= gap_r + 16'h1;
        end
        seen_r <= sys_rst ? 1'h0 : (seen_r | line_start);
    end
    // ========
    // Pin pulse width and rise age
    always_ff @(posedge core_clk) begin
        low_r <= hsync_n ? 16'h0 : low_r + 16'h1;
        if (hsync_n && low_r != 16'h0) begin
            wid_r <= low_r;
        end
        rise_r <= (hsync_n && low_r != 16'h0) ? 4'h0 : rise_r + {3'h0, rise_r != 4'hf};
    end
    // ========
    // Properties
    AST_LS_PULSE: assert property (line_start |=> !line_start)
        else $error("line pulse longer than one cycle");
    AST_HOLDOFF: assert property (line_start && seen_r |-> gap_r >= HOLDOFF)
        else $error("line pulse inside hold-off");
    AST_PSEUDO: assert property (seen_r && clk_en && gap_r == PSEUDO - 1 |-> line_start)
        else $error("pseudo line pulse missing");
    AST_WIDTH: assert property (line_start && seen_r && gap_r != PSEUDO - 1
        |-> wid_r >= 16'h28 && rise_r <= 4'h4)
        else $error("line pulse without a wide enough pin pulse");
    AST_B_AFTER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_B_STAND: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_R_STAND: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    // Main scenarios reached
    COV_PSEUDO: cover property (seen_r && gap_r == PSEUDO - 1 && line_start);
    COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
    COV_READ: cover property (s_axi_rvalid && s_axi_rready);
endmodule // osd_timing_checker

bind osd_sync_position_timing osd_timing_checker #(.HOLDOFF(HOLDOFF), .PSEUDO(PSEUDO)) prop_chk (
    .core_clk, .sys_rst, .clk_en, .hsync_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .line_start);
`default_nettype wire

// [verification/sync_source.sv]
`timescale 1ns/1ps
`default_nettype none
// ========
// Video sync source: negative syncs, free dot clock
module sync_source (
    // Clock
    input wire logic core_clk,
    // Sync pins
    output logic hsync_n,
    output logic vsync_n,
    output logic csync_n,
    output logic dot_clk_ext
);
    logic [1:0] div_r = 2'h0; // External dot clock divider
    // Idle syncs sit high, pulses go low
    initial begin
        hsync_n = 1'h1;
        vsync_n = 1'h1;
        csync_n = 1'h1;
        dot_clk_ext = 1'h0;
    end
    // Free-running, so ungated ticks show
    always @(posedge core_clk) begin
        div_r <= div_r + 2'h1;
        if (div_r == 2'h3) begin
            dot_clk_ext <= ~dot_clk_ext;
        end
    end
    // One low pulse on hsync and csync
    task automatic hpulse(input int low);
        if (low > 0) begin
            @(posedge core_clk);
            {hsync_n, csync_n} <= 2'h0;
            repeat (low) @(posedge core_clk);
            {hsync_n, csync_n} <= 2'h3;
        end
    endtask
endmodule // sync_source
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ========
// Bench top
module tb_top;
    import osd_timing_pkg::*;
    logic core_clk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1;
    logic hsync_n, vsync_n, csync_n, dot_clk_ext, line_start, dot_tick;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int fail_count = 0, n_compared = 0, cyc = 0, ls_n = 0, dt_n = 0;
    always #2.5 core_clk = ~core_clk;
    // Short counts keep the run brief
    osd_sync_position_timing #(.HOLDOFF(50), .PSEUDO(80)) dut (.core_clk, .sys_rst, .clk_en,
        .power_on_clear(1'h0), .hsync_n, .vsync_n, .csync_n, .dot_clk_ext, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .line_start, .dot_tick, .disp_active(), .cell_col(), .cell_row(),
        .font_line(), .char_code());
    sync_source src (.core_clk, .hsync_n, .vsync_n, .csync_n, .dot_clk_ext);
    // Event counters for the scenarios
    always @(posedge core_clk) begin
        ls_n <= ls_n + int'(line_start === 1'h1);
        dt_n <= dt_n + int'(dot_tick === 1'h1);
    end
    // Hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            $display("BAD timeout exp 0 got 1");
            final_report;
        end
    end
    task automatic final_report;
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // ========
    // Bus master
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk("bresp", 32'(RESP_OKAY), 32'(s_axi_bresp));
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axr(a, d, r);
        chk("rdata", e, d);
        chk("rresp", 32'(er), 32'(r));
    endtask
    // ========
    // Scenarios
    task automatic t_regs;
        rd(CTRL_OFS, 32'(CTRL_RST), RESP_OKAY);
        rd(HSTART_OFS, 32'(HSTART_RST), RESP_OKAY);
        rd(VSTART_OFS, 32'(VSTART_RST), RESP_OKAY);
        rd(8'h40, 32'h0, RESP_SLVERR);
        axw(HSTART_OFS, 32'h3ff);
        rd(HSTART_OFS, 32'h3ff, RESP_OKAY);
    endtask
    task automatic t_vram;
        int k;
        logic [31:0] d;
        logic [1:0] r;
        axw(VADDR_OFS, 32'h11f);
        axw(VDATA_OFS, 32'h1a5);
        rd(VDATA_OFS, 32'h1a5, RESP_OKAY);
        axw(VADDR_OFS, 32'h120);
        axw(VDATA_OFS, 32'h5);
        rd(VDATA_OFS, 32'h0, RESP_OKAY);
        axw(CLEAR_OFS, 32'h1);
        axr(CLEAR_OFS, d, r);
        chk("clear_start", 32'h1, d);
        for (k = 0; k < 150 && d[0] !== 1'h0; k++) axr(CLEAR_OFS, d, r);
        chk("clear_end", 32'h0, d);
        axw(VADDR_OFS, 32'h11f);
        rd(VDATA_OFS, 32'h0, RESP_OKAY);
    endtask
    // Pulse after a line pulse, lines counted
    task automatic hcase(input int pre, input int low, input int want);
        int n0;
        @(posedge core_clk);
        while (line_start !== 1'h1) @(posedge core_clk);
        @(posedge core_clk);
        n0 = ls_n;
        repeat (pre) @(posedge core_clk);
        src.hpulse(low);
        repeat (6) @(posedge core_clk);
        chk("line_starts", 32'(want), 32'(ls_n - n0));
    endtask
    // Dot ticks in a long low phase, per mode
    task automatic t_dot;
        int k, d0;
        logic [6:0] cv [3];
        cv = '{7'h03, 7'h02, 7'h07};
        for (k = 0; k < 3; k++) begin
            axw(CTRL_OFS, 32'(cv[k]));
            fork
                src.hpulse(100);
                begin
                    repeat (10) @(posedge core_clk);
                    d0 = dt_n;
                    repeat (80) @(posedge core_clk);
                    d0 = dt_n - d0;
                end
            join
            chk("dot_run", 32'(k != 0), 32'(d0 != 0));
        end
        axw(CTRL_OFS, 32'h02);
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'h0;
        t_regs;
        t_vram;
        hcase(0, 60, 1);
        hcase(35, 20, 0);
        hcase(0, 42, 0);
        hcase(84, 0, 1);
        axw(CTRL_OFS, 32'h42);
        hcase(0, 60, 0);
        axw(CTRL_OFS, 32'h1a);
        hcase(0, 60, 1);
        axw(CTRL_OFS, 32'h02);
        t_dot;
        final_report;
    end
endmodule // tb_top
`default_nettype wire
